/* pwk_pkg.sv */
// Purpose: shared constants and types for the port pin event and wakeup block
// Assumes: 32-bit AHB-Lite register bus, word per register
// Notes:   register indices are multiplied by four to form byte addresses
package pwk_pkg;
  // register indices (byte address = index * 4)
  localparam logic [11:0] IDX_PULL_E    = 12'h0266;
  localparam logic [11:0] IDX_PULL_ADH  = 12'h0286;
  localparam logic [11:0] IDX_PULL_ADL  = 12'h0287;
  localparam logic [11:0] IDX_PULL_T    = 12'h02c3;
  localparam logic [11:0] IDX_PULL_S    = 12'h02d3;
  localparam logic [11:0] IDX_PULL_P    = 12'h02f3;
  localparam logic [11:0] IDX_PULL_J    = 12'h0313;
  localparam logic [11:0] IDX_EVT_EN    = 12'h0320;
  localparam logic [11:0] IDX_EVT_POL   = 12'h0321;
  localparam logic [11:0] IDX_EVT_FLAG  = 12'h0322;
  localparam logic [11:0] IDX_PULL_POL  = 12'h0323;
  localparam logic [11:0] IDX_EXT_CTRL  = 12'h0324;
  localparam logic [11:0] IDX_STATUS    = 12'h0325;
  // reset values
  localparam logic [7:0]  RST_PULL_EJ   = 8'h03;
  localparam logic [7:0]  RST_PULL_S    = 8'h0f;
  localparam logic [7:0]  RST_PULL_OTH  = 8'h00;
  // event pin layout: ad[15:0] s[19:16] p[27:20] hv[28]
  localparam int          NEVT          = 29;
  localparam int          POS_AD        = 0;
  localparam int          POS_S         = 16;
  localparam int          POS_P         = 20;
  localparam int          POS_HV        = 28;
  // pull pins: e, adh, adl, t, s, p, j, eight each
  localparam int          NPULL         = 56;
  // filter: passive run then active run of this many samples
  localparam logic [2:0]  FILT_RUN      = 3'h4;
  localparam logic [2:0]  FILT_LAST     = 3'h7;
  // capture reroute selector codes
  localparam logic [1:0]  CAP_SERIAL0   = 2'h1;
  localparam logic [1:0]  CAP_SERIAL1   = 2'h2;
  // ahb
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0]  HTRANS_SEQ    = 2'h3;

  // control register fields, high bits first
  typedef struct packed {
    logic       hv_digital_input_enable;  // bit 5
    logic       hv_analog_path_enable;    // bit 4
    logic [1:0] capture_reroute_select;   // bits 3:2
    logic       ext_request_control;      // bit 1: 1 = falling edge
    logic       ext_request_enable;       // bit 0
  } pwk_ctrl_t;
  localparam pwk_ctrl_t RST_CTRL = '0;

  // captured address phase
  typedef struct packed {
    logic        write;
    logic [11:0] index;
  } pwk_addr_t;

  typedef enum logic [1:0] {
    BUS_IDLE  = 2'b01,
    BUS_RWAIT = 2'b10
  } pwk_bus_t;
endpackage

/* pwk_port_wakeup.sv */
// Purpose: pin event filters, port requests, key wakeup, external request pins,
//          pull device control, high voltage digital input and capture reroute
// Assumes: one bus clock, asynchronous active low reset, AHB-Lite slave
// Notes:   reads take one wait state, writes none
//
// Summary of operation
// RULE1: edge accepted after four passive samples then four active samples
// RULE2: broken passive or active run restarts the sampling sequence
// RULE3: port request whenever a pin flag and its enable are both set
// RULE4: enable and edge polarity configurable per pin
// RULE5: all pins of a port share one request line
// RULE6: edge detection works whether pin is input or output
// RULE7: enabled pin request also raises wakeup from stop and wait
// RULE8: filters sample on every bus clock cycle
// RULE9: maskable pin off after reset, needs enable set and cpu mask clear
// RULE10: maskable pin selectable level or falling edge triggered
// RULE11: clearing maskable enable drops a pending request at once
// RULE12: nonmaskable pin masked while the cpu nonmaskable mask is set
// RULE13: both external pins can wake the device from stop
// RULE14: external pins have no glitch filter
// RULE15: pull enable bit turns pull device on, ignored for push-pull output
// RULE16: pull direction follows polarity; open-drain allows pull-up only
// RULE17: pull enable registers readable and writable any time
// RULE18: hv buffer on only with digital enable in digital mode; state readable
// RULE19: selector 01 feeds capture channel 3 from serial 0 receive
// RULE20: selector 10 feeds capture channel 3 from serial 1 receive
// RULE21: flag set by filtered edge, cleared by writing one
//
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/1ps
module pwk_port_wakeup
  import pwk_pkg::*;
(
  // clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // ahb-lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  // event pins, asynchronous pad levels
  input  wire logic [NEVT-1:0]   evt_pin,
  // external request pins, active low, asynchronous
  input  wire logic              ext_request_pin_n,
  input  wire logic              nonmaskable_ext_pin_n,
  // cpu side
  input  wire logic              cpu_i_mask,
  input  wire logic              cpu_x_mask,
  input  wire logic              ext_request_ack,
  output logic      [3:0]        port_request,
  output logic                   key_wakeup,
  output logic                   ext_request,
  output logic                   nonmaskable_request,
  output logic                   ext_wakeup,
  // pull device control
  input  wire logic [NPULL-1:0]  pin_push_pull,
  input  wire logic [NPULL-1:0]  pin_open_drain,
  output logic      [NPULL-1:0]  pull_up_en,
  output logic      [NPULL-1:0]  pull_down_en,
  // high voltage input
  output logic                   hv_buffer_enable,
  // capture reroute
  input  wire logic              timer_capture_pin3,
  input  wire logic              serial0_receive,
  input  wire logic              serial1_receive,
  output logic                   capture_in3
);

  // filter step: returns {edge, next count}
  function automatic logic [3:0] filt_step(input logic [2:0] cnt, input logic active);
    logic [3:0] r;
    r = {1'b0, cnt};
    if (!active) begin
      if (cnt < FILT_RUN) r = {1'b0, cnt + 3'h1};
      else if (cnt > FILT_RUN) r = {1'b0, 3'h1}; // RULE2
      else r = {1'b0, FILT_RUN};
    end else begin
      if (cnt < FILT_RUN) r = {1'b0, 3'h0}; // RULE2
      else if (cnt == FILT_LAST) r = {1'b1, 3'h0}; // RULE1
      else r = {1'b0, cnt + 3'h1}; // RULE1
    end
    return r;
  endfunction

  // register state
  logic [7:0]      pull_e_reg, pull_adh_reg, pull_adl_reg, pull_t_reg;
  logic [7:0]      pull_s_reg, pull_p_reg, pull_j_reg;
  logic [NEVT-1:0] evt_en_reg, evt_pol_reg, evt_flag_reg;
  logic [27:0]     pull_pol_reg;
  pwk_ctrl_t       ctrl_reg;
  // bus state
  pwk_bus_t        bus_reg;
  pwk_addr_t       aph_reg;
  logic            wr_pend_reg;
  // synchronisers
  logic [NEVT-1:0] evt_s1_reg, evt_s2_reg;
  logic            irq_s1_reg, irq_s2_reg, irq_prev_reg;
  logic            nonmaskable_ext_pin_s1_reg, nonmaskable_ext_pin_s2_reg;
  logic            cap_s1_reg, cap_s2_reg;
  // filters and external request latch
  logic [2:0]      filt_cnt_reg [NEVT];
  logic [NEVT-1:0] evt_edge;
  logic [3:0]      filt_res [NEVT];
  logic            irq_latch_reg;

  // bus decode
  logic            wr_do;
  logic [NEVT-1:0] flag_clr;
  logic [31:0]     rd_word;
  logic            hv_state;
  logic            irq_pending;

  // writes land in their data phase; a one in the flag word clears that flag
  assign wr_do    = wr_pend_reg;
  assign flag_clr = (wr_do && aph_reg.index == IDX_EVT_FLAG) ? hwdata[NEVT-1:0] : '0;

  // address phase capture and read wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_reg     <= BUS_IDLE;
      aph_reg     <= '0;
      wr_pend_reg <= 1'b0;
      hreadyout   <= 1'b1;
      hrdata      <= 32'h0000_0000;
    end else begin
      case (bus_reg)
        BUS_IDLE: begin
          wr_pend_reg <= 1'b0;
          if (hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ)) begin
            aph_reg <= '{write: hwrite, index: haddr[13:2]};
            if (hwrite) begin
              wr_pend_reg <= 1'b1;
            end else begin
              bus_reg   <= BUS_RWAIT;
              hreadyout <= 1'b0;
            end
          end
        end
        BUS_RWAIT: begin
          // read data stands until the next read completes
          hrdata    <= rd_word;
          hreadyout <= 1'b1;
          bus_reg   <= BUS_IDLE;
        end
        default: begin
          bus_reg   <= BUS_IDLE;
          hreadyout <= 1'b1;
        end
      endcase
    end
  end

  // response is always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hresp <= 1'b0;
    else hresp <= 1'b0;
  end

  // read mux, unmapped reads as zero
  always_comb begin
    rd_word = 32'h0000_0000;
    case (aph_reg.index)
      IDX_PULL_E:   rd_word = {24'h00_0000, pull_e_reg}; // RULE17
      IDX_PULL_ADH: rd_word = {24'h00_0000, pull_adh_reg};
      IDX_PULL_ADL: rd_word = {24'h00_0000, pull_adl_reg};
      IDX_PULL_T:   rd_word = {24'h00_0000, pull_t_reg};
      IDX_PULL_S:   rd_word = {24'h00_0000, pull_s_reg};
      IDX_PULL_P:   rd_word = {24'h00_0000, pull_p_reg};
      IDX_PULL_J:   rd_word = {24'h00_0000, pull_j_reg};
      IDX_EVT_EN:   rd_word = {3'h0, evt_en_reg};
      IDX_EVT_POL:  rd_word = {3'h0, evt_pol_reg};
      IDX_EVT_FLAG: rd_word = {3'h0, evt_flag_reg};
      IDX_PULL_POL: rd_word = {4'h0, pull_pol_reg};
      IDX_EXT_CTRL: rd_word = {26'h000_0000, ctrl_reg};
      IDX_STATUS:   rd_word = {24'h00_0000, port_request, 1'b0, ~nonmaskable_ext_pin_s2_reg,
                               irq_pending, hv_state}; // RULE18
      default:      rd_word = 32'h0000_0000;
    endcase
  end

  // pull enable registers, written any time
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pull_e_reg   <= RST_PULL_EJ;
      pull_adh_reg <= RST_PULL_OTH;
      pull_adl_reg <= RST_PULL_OTH;
      pull_t_reg   <= RST_PULL_OTH;
      pull_s_reg   <= RST_PULL_S;
      pull_p_reg   <= RST_PULL_OTH;
      pull_j_reg   <= RST_PULL_EJ;
    end else if (wr_do) begin
      case (aph_reg.index)
        IDX_PULL_E:   pull_e_reg   <= hwdata[7:0]; // RULE17
        IDX_PULL_ADH: pull_adh_reg <= hwdata[7:0];
        IDX_PULL_ADL: pull_adl_reg <= hwdata[7:0];
        IDX_PULL_T:   pull_t_reg   <= hwdata[7:0];
        IDX_PULL_S:   pull_s_reg   <= hwdata[7:0];
        IDX_PULL_P:   pull_p_reg   <= hwdata[7:0];
        IDX_PULL_J:   pull_j_reg   <= hwdata[7:0];
        default: ;
      endcase
    end
  end

  // per pin enable, polarity and control registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      evt_en_reg   <= '0;
      evt_pol_reg  <= '0;
      pull_pol_reg <= '0;
      ctrl_reg     <= RST_CTRL; // RULE9
    end else if (wr_do) begin
      case (aph_reg.index)
        IDX_EVT_EN:   evt_en_reg   <= hwdata[NEVT-1:0]; // RULE4
        IDX_EVT_POL:  evt_pol_reg  <= hwdata[NEVT-1:0]; // RULE4
        IDX_PULL_POL: pull_pol_reg <= hwdata[27:0];
        IDX_EXT_CTRL: ctrl_reg     <= pwk_ctrl_t'(hwdata[5:0]);
        default: ;
      endcase
    end
  end

  // two-stage synchronisers for all pad inputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      evt_s1_reg  <= '0;
      evt_s2_reg  <= '0;
      irq_s1_reg  <= 1'b1;
      irq_s2_reg  <= 1'b1;
      nonmaskable_ext_pin_s1_reg <= 1'b1;
      nonmaskable_ext_pin_s2_reg <= 1'b1;
      cap_s1_reg  <= 1'b0;
      cap_s2_reg  <= 1'b0;
    end else begin
      evt_s1_reg  <= evt_pin; // RULE6
      evt_s2_reg  <= evt_s1_reg;
      irq_s1_reg  <= ext_request_pin_n;
      irq_s2_reg  <= irq_s1_reg;
      nonmaskable_ext_pin_s1_reg <= nonmaskable_ext_pin_n;
      nonmaskable_ext_pin_s2_reg <= nonmaskable_ext_pin_s1_reg;
      cap_s1_reg  <= timer_capture_pin3;
      cap_s2_reg  <= cap_s1_reg;
    end
  end

  // hv level only passes with the digital buffer on
  assign hv_state = evt_s2_reg[POS_HV] & ~ctrl_reg.hv_analog_path_enable
                    & ctrl_reg.hv_digital_input_enable; // RULE18

  // active level of a pin after polarity, hv pin gated
  function automatic logic evt_lvl(input int i);
    logic lvl;
    // hv pin shows a steady low while its buffer is off
    lvl = (i == POS_HV) ? hv_state : evt_s2_reg[i];
    return ~(lvl ^ evt_pol_reg[i]) ? 1'b1 : 1'b0;
  endfunction

  // next filter counts and edge strobes
  always_comb begin
    evt_edge = '0;
    for (int i = 0; i < NEVT; i++) begin
      filt_res[i] = filt_step(filt_cnt_reg[i], evt_lvl(i));
      evt_edge[i] = filt_res[i][3]; // RULE1
    end
  end

  // glitch filters, stepped every bus clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NEVT; i++) begin
        filt_cnt_reg[i] <= 3'h0;
      end
    end else begin
      for (int i = 0; i < NEVT; i++) begin
        filt_cnt_reg[i] <= filt_res[i][2:0]; // RULE8
      end
    end
  end

  // event flags, a new edge wins over a clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) evt_flag_reg <= '0;
    else evt_flag_reg <= (evt_flag_reg & ~flag_clr) | evt_edge; // RULE21
  end

  // per port requests and key wakeup
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_request <= 4'h0;
      key_wakeup   <= 1'b0;
    end else begin
      port_request[0] <= |(evt_flag_reg[POS_S-1:POS_AD] & evt_en_reg[POS_S-1:POS_AD]); // RULE5
      port_request[1] <= |(evt_flag_reg[POS_P-1:POS_S] & evt_en_reg[POS_P-1:POS_S]); // RULE5
      port_request[2] <= |(evt_flag_reg[POS_HV-1:POS_P] & evt_en_reg[POS_HV-1:POS_P]); // RULE3
      port_request[3] <= evt_flag_reg[POS_HV] & evt_en_reg[POS_HV]; // RULE3
      key_wakeup      <= |(evt_flag_reg & evt_en_reg); // RULE7
    end
  end

  // maskable pin: falling edge latch, dropped by ack or enable clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_prev_reg  <= 1'b1;
      irq_latch_reg <= 1'b0;
    end else begin
      irq_prev_reg <= irq_s2_reg; // RULE14
      if (!ctrl_reg.ext_request_enable || !ctrl_reg.ext_request_control) irq_latch_reg <= 1'b0; // RULE11
      else if (irq_prev_reg && !irq_s2_reg) irq_latch_reg <= 1'b1; // RULE10
      else if (ext_request_ack) irq_latch_reg <= 1'b0;
    end
  end

  // maskable pending level, before the cpu mask
  assign irq_pending = ctrl_reg.ext_request_enable &
                       (ctrl_reg.ext_request_control ? irq_latch_reg : ~irq_s2_reg); // RULE10

  // external request outputs and stop wakeup
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_request         <= 1'b0;
      nonmaskable_request <= 1'b0;
      ext_wakeup          <= 1'b0;
    end else begin
      ext_request         <= irq_pending & ~cpu_i_mask; // RULE9
      nonmaskable_request <= ~nonmaskable_ext_pin_s2_reg & ~cpu_x_mask; // RULE12
      ext_wakeup          <= (irq_pending & ~cpu_i_mask) | (~nonmaskable_ext_pin_s2_reg & ~cpu_x_mask); // RULE13
    end
  end

  // pull control, polarity per pull pin
  logic [NPULL-1:0] pull_en_all, pull_pol_all;
  assign pull_en_all  = {pull_j_reg, pull_p_reg, pull_s_reg, pull_t_reg,
                         pull_adl_reg, pull_adh_reg, pull_e_reg};
  assign pull_pol_all = {pull_pol_reg[23:16], evt_pol_reg[POS_HV-1:POS_P],
                         pull_pol_reg[27:24], evt_pol_reg[POS_P-1:POS_S],
                         pull_pol_reg[15:8], evt_pol_reg[7:0], evt_pol_reg[15:8],
                         pull_pol_reg[7:0]};

  // pull devices off for push-pull pins, pull-up only on open drain
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pull_up_en   <= '0;
      pull_down_en <= '0;
    end else begin
      pull_up_en   <= pull_en_all & ~pin_push_pull & (pin_open_drain | ~pull_pol_all); // RULE15
      pull_down_en <= pull_en_all & ~pin_push_pull & ~pin_open_drain & pull_pol_all; // RULE16
    end
  end

  // hv buffer enable and capture reroute
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hv_buffer_enable <= 1'b0;
      capture_in3      <= 1'b0;
    end else begin
      hv_buffer_enable <= ~ctrl_reg.hv_analog_path_enable
                          & ctrl_reg.hv_digital_input_enable; // RULE18
      case (ctrl_reg.capture_reroute_select)
        CAP_SERIAL0: capture_in3 <= serial0_receive; // RULE19
        CAP_SERIAL1: capture_in3 <= serial1_receive; // RULE20
        default:     capture_in3 <= cap_s2_reg;
      endcase
    end
  end

endmodule

/* pwk_port_wakeup_asserts.sv */
// Purpose: concurrent checks on the port pin event and wakeup block
// Assumes: single bus clock, asynchronous active low reset
// Notes:   bound to every instance of the block
`timescale 1ns/1ps
module pwk_port_wakeup_asserts
  import pwk_pkg::*;
(
  // clock and reset
  input wire logic             hclk,
  input wire logic             hresetn,
  // bus
  input wire logic             hsel,
  input wire logic [1:0]       htrans,
  input wire logic             hwrite,
  input wire logic             hready,
  input wire logic             hreadyout,
  // cpu side
  input wire logic             cpu_i_mask,
  input wire logic             cpu_x_mask,
  input wire logic             nonmaskable_ext_pin_n,
  input wire logic [3:0]       port_request,
  input wire logic             key_wakeup,
  input wire logic             ext_request,
  input wire logic             nonmaskable_request,
  input wire logic             ext_wakeup,
  // pull control
  input wire logic [NPULL-1:0] pin_push_pull,
  input wire logic [NPULL-1:0] pin_open_drain,
  input wire logic [NPULL-1:0] pull_up_en,
  input wire logic [NPULL-1:0] pull_down_en
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // reads stall exactly one cycle, writes never
  property p_rd_wait;
    hsel && hready && htrans == HTRANS_NONSEQ && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read lacks one wait state");
  property p_wr_fast;
    hsel && hready && htrans == HTRANS_NONSEQ && hwrite |=> hreadyout;
  endproperty
  a_wr_fast: assert property (p_wr_fast) else $error("write stalled");
  // wakeup follows any port request
  property p_kwu;
    key_wakeup == (|port_request);
  endproperty
  a_kwu: assert property (p_kwu) else $error("key wakeup differs from port requests");
  // cpu masks block the external requests
  property p_imask;
    cpu_i_mask |=> !ext_request;
  endproperty
  a_imask: assert property (p_imask) else $error("maskable request while masked");
  property p_xmask;
    cpu_x_mask |=> !nonmaskable_request;
  endproperty
  a_xmask: assert property (p_xmask) else $error("nonmaskable request while masked");
  // unfiltered pin reaches the request in three edges
  property p_nmi_direct;
    (!nonmaskable_ext_pin_n && !cpu_x_mask) [*4] |-> nonmaskable_request;
  endproperty
  a_nmi_direct: assert property (p_nmi_direct) else $error("nonmaskable pin too slow");
  property p_wake;
    ext_request || nonmaskable_request |-> ext_wakeup;
  endproperty
  a_wake: assert property (p_wake) else $error("request without wakeup");
  // pull devices off for push-pull, never both, no pull-down on open drain
  property p_pp;
    ((pull_up_en | pull_down_en) & $past(pin_push_pull)) == '0;
  endproperty
  a_pp: assert property (p_pp) else $error("pull active on push-pull pin");
  property p_od;
    (pull_down_en & $past(pin_open_drain)) == '0;
  endproperty
  a_od: assert property (p_od) else $error("pull-down on open drain pin");
  property p_excl;
    (pull_up_en & pull_down_en) == '0;
  endproperty
  a_excl: assert property (p_excl) else $error("pull-up and pull-down together");
endmodule

bind pwk_port_wakeup pwk_port_wakeup_asserts u_chk (.*);

/* pwk_pin_model.sv */
// Purpose: keys and switches on the event pins
// Assumes: bench sets the wanted pad levels
// Notes:   chatter makes the contacts bounce every cycle
`timescale 1ns/1ps
module pwk_pin_model
  import pwk_pkg::*;
(
  // clock
  input wire logic            hclk,
  // wanted levels
  input wire logic [NEVT-1:0] want_evt,
  input wire logic            chatter,
  // pads
  output logic     [NEVT-1:0] evt_pin
);
  logic tgl_reg = 1'b0;
  // bounce phase flips each cycle
  always_ff @(posedge hclk) tgl_reg <= ~tgl_reg;
  // pads show the wanted level, or a bouncing one
  assign evt_pin = chatter ? want_evt ^ {NEVT{tgl_reg}} : want_evt;
endmodule

/* port_pin_interrupt_wakeup_test.sv */
// Purpose: self-checking bench for the port pin event and wakeup block
// Assumes: 100 MHz hclk, single word AHB-Lite transfers
// Notes:   pin filter expectations come from a stepped software model
`timescale 1ns/1ps
module port_pin_interrupt_wakeup_test;
  import pwk_pkg::*;
  localparam logic [11:0] PIDX [7] = '{IDX_PULL_E, IDX_PULL_ADH, IDX_PULL_ADL, IDX_PULL_T,
                                       IDX_PULL_S, IDX_PULL_P, IDX_PULL_J};
  localparam logic [7:0]  PRST [7] = '{RST_PULL_EJ, 8'h00, 8'h00, 8'h00, RST_PULL_S, 8'h00,
                                       RST_PULL_EJ};
  logic             hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, lv;
  logic [31:0]      haddr = '0, hwdata = '0, hrdata, rd, rnd = 32'h0000_b437;
  logic [1:0]       htrans = '0;
  logic             hreadyout, hresp, chatter = 1'b0, ext_n = 1'b1, nmi_n = 1'b1;
  logic             imask = 1'b1, xmask = 1'b1, ack = 1'b0, tcap = 1'b0, s0 = 1'b0, s1 = 1'b0;
  logic             key_wakeup, ext_request, nm_req, ext_wakeup, hv_buf, cap3;
  logic [3:0]       port_request;
  logic [NEVT-1:0]  want = '0, evt_pin, en, pol;
  logic [NPULL-1:0] pp = '0, od = '0, pu, pd;
  int               num_errors = 0, n_checks = 0, pc = 0, ac = 0, hits;

  pwk_port_wakeup u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .evt_pin(evt_pin),
    .ext_request_pin_n(ext_n), .nonmaskable_ext_pin_n(nmi_n), .cpu_i_mask(imask),
    .cpu_x_mask(xmask), .ext_request_ack(ack), .port_request(port_request),
    .key_wakeup(key_wakeup), .ext_request(ext_request), .nonmaskable_request(nm_req),
    .ext_wakeup(ext_wakeup), .pin_push_pull(pp), .pin_open_drain(od), .pull_up_en(pu),
    .pull_down_en(pd), .hv_buffer_enable(hv_buf), .timer_capture_pin3(tcap),
    .serial0_receive(s0), .serial1_receive(s1), .capture_in3(cap3));
  pwk_pin_model u_pins (.hclk(hclk), .want_evt(want), .chatter(chatter), .evt_pin(evt_pin));

  // bus clock
  always #5 hclk = ~hclk;
  // pseudo random source
  function automatic logic [31:0] lfsr_step(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // port request expected from the flag and enable pattern
  function automatic logic [3:0] preq(input logic [NEVT-1:0] f);
    return {f[28], |f[27:20], |f[19:16], |f[15:0]};
  endfunction
  // single word transfer, each phase held until hready is seen high
  task automatic bus(input logic w, input logic [11:0] idx, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {18'h0, idx, 2'b00};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // compare and count
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_reg(input logic [11:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    chk(rd, exp);
  endtask
  // filter model for pin 0: four passive then four active samples
  task automatic step(input logic act);
    if (act && pc == 4) begin
      ac++;
      if (ac == 4) begin
        hits++;
        pc = 0;
        ac = 0;
      end
    end else if (act) begin
      pc = 0;
    end else begin
      pc = (ac > 0) ? 1 : ((pc < 4) ? pc + 1 : 4);
      ac = 0;
    end
  endtask
  task automatic drive(input logic lvl, input int n);
    repeat (n) begin
      @(posedge hclk);
      want[0] <= lvl;
      step(lvl);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // cut a hang short, far beyond the roughly one thousand cycles needed
  initial begin
    #200_000;
    num_errors++;
    complete_run;
  end

  // main sequence
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      chk_reg(PIDX[i], {24'h0, PRST[i]});
      rnd = lfsr_step(rnd);
      bus(1'b1, PIDX[i], rnd);
      chk_reg(PIDX[i], {24'h0, rnd[7:0]});
    end
    chk_reg(12'h0100, 32'h0);
    chk(hresp, 1'b0);
    repeat (4) begin
      rnd = lfsr_step(rnd);
      bus(1'b1, IDX_PULL_E, rnd);
      bus(1'b1, IDX_PULL_POL, rnd >> 8);
      pp <= {2{rnd[27:0]}};
      od <= {2{rnd[31:4]}};
      repeat (2) @(posedge hclk);
      chk(pu[7:0], rnd[7:0] & ~pp[7:0] & (od[7:0] | ~rnd[15:8]));
      chk(pd[7:0], rnd[7:0] & ~pp[7:0] & ~od[7:0] & rnd[15:8]);
    end
    $display("pull test done");
    bus(1'b1, IDX_EVT_POL, 32'h0000_0001);
    bus(1'b1, IDX_EVT_EN, 32'h0000_0001);
    drive(1'b0, 8);
    repeat (8) begin
      hits = 0;
      lv = 1'b0;
      repeat (6) begin
        rnd = lfsr_step(rnd);
        lv = ~lv;
        drive(lv, 1 + int'(rnd % 6));
      end
      drive(1'b0, 6);
      chk_reg(IDX_EVT_FLAG, {31'h0, hits > 0});
      chk({key_wakeup, port_request}, {hits > 0, 3'h0, hits > 0});
      bus(1'b1, IDX_EVT_FLAG, 32'h0);
      chk_reg(IDX_EVT_FLAG, {31'h0, hits > 0});
      bus(1'b1, IDX_EVT_FLAG, 32'h1);
      chk_reg(IDX_EVT_FLAG, 32'h0);
    end
    chatter <= 1'b1;
    repeat (40) @(posedge hclk);
    chatter <= 1'b0;
    chk_reg(IDX_EVT_FLAG, 32'h0);
    $display("filter test done");
    bus(1'b1, IDX_EXT_CTRL, 32'h0000_0020);
    repeat (3) begin
      rnd = lfsr_step(rnd);
      en = rnd[28:0];
      pol = rnd[31:3];
      bus(1'b1, IDX_EVT_EN, {3'h0, en});
      bus(1'b1, IDX_EVT_POL, {3'h0, pol});
      want <= ~pol;
      repeat (6) @(posedge hclk);
      want <= pol;
      repeat (6) @(posedge hclk);
      want <= ~pol;
      repeat (6) @(posedge hclk);
      chk_reg(IDX_EVT_FLAG, 32'h1fff_ffff);
      chk(port_request, preq(en));
      chk(key_wakeup, |en);
      bus(1'b1, IDX_EVT_FLAG, {3'h0, pol});
      chk_reg(IDX_EVT_FLAG, {3'h0, ~pol});
      chk(port_request, preq(en & ~pol));
      bus(1'b1, IDX_EVT_FLAG, 32'hffff_ffff);
    end
    $display("pin event test done");
    ext_n <= 1'b0;
    imask <= 1'b0;
    repeat (5) @(posedge hclk);
    chk(ext_request, 1'b0);
    bus(1'b1, IDX_EXT_CTRL, 32'h0000_0021);
    repeat (5) @(posedge hclk);
    chk({ext_request, ext_wakeup}, 2'b11);
    bus(1'b1, IDX_EXT_CTRL, 32'h0000_0020);
    repeat (2) @(posedge hclk);
    chk(ext_request, 1'b0);
    ext_n <= 1'b1;
    bus(1'b1, IDX_EXT_CTRL, 32'h0000_0023);
    ext_n <= 1'b0;
    repeat (3) @(posedge hclk);
    ext_n <= 1'b1;
    repeat (5) @(posedge hclk);
    chk(ext_request, 1'b1);
    ack <= 1'b1;
    @(posedge hclk);
    ack <= 1'b0;
    repeat (4) @(posedge hclk);
    chk(ext_request, 1'b0);
    nmi_n <= 1'b0;
    repeat (5) @(posedge hclk);
    chk(nm_req, 1'b0);
    xmask <= 1'b0;
    repeat (4) @(posedge hclk);
    chk({nm_req, ext_wakeup}, 2'b11);
    bus(1'b0, IDX_STATUS, 32'h0);
    chk(rd[2], 1'b1);
    $display("external pin test done");
    want[28] <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      rnd = lfsr_step(rnd);
      {tcap, s0, s1} <= rnd[2:0];
      bus(1'b1, IDX_EXT_CTRL, {26'h0, i[3:0], 2'h0});
      repeat (4) @(posedge hclk);
      chk(cap3, (i[1:0] == 2'h1) ? s0 : (i[1:0] == 2'h2) ? s1 : tcap);
      chk(hv_buf, i[3] & ~i[2]);
      bus(1'b0, IDX_STATUS, 32'h0);
      chk(rd[0], i[3] & ~i[2]);
    end
    $display("control test done");
    complete_run;
  end
endmodule
